/* rtl/lin_register_access_and_errors.sv */
// LIN controller register bank: config, indirect address/data pair and
// the fifteen core registers, plus error stop and interrupt handling.
// Assumes the core's SFR bus gives one-cycle rd/wr strobes with an address;
// frame engine events arrive as one-cycle pulses synchronous to clk.
//
// Behaviour
// - Any error stops frame, raises interrupt
// - Reset-error write clears error flags, summary
// - Error pending blocks master start, wakeup
// - Eight-bit pointer selects core register, resets zero
// - Data register reads/writes selected core register
// - Config bit seven enables controller
// - Config bit six selects master, resets master
// - Config bit five selects autobaud, slave only out of reset; output resets high
// - Config bits four..zero read zero
// - Fifteen core registers decoded at 0x00-0x0E
// - Master-only and slave-only bits gated by role
// - Error flags: sync, parity, timeout, checksum, bit
// - Length has enhanced select, identifier six bits
// - Eight data bytes, read/write, reset zero
// - Reset-error bit always reads zero
// - Start request self-clears on done or error
`timescale 1ns/1ps
`include "lin_regs_map.svh"
module lin_register_access_and_errors (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	input wire logic frame_done,
	input wire logic [4:0] frame_error,
	input wire logic bus_active,
	input wire logic data_request,
	input wire logic wakeup_seen,
	input wire logic ack_taken,
	output logic interface_enable,
	output lin_regs_pkg::lin_role_t role,
	output logic auto_baud_select,
	output logic start_request,
	output logic wakeup_request,
	output logic frame_abort,
	output logic irq
);
	import lin_regs_pkg::*;

	// Config bits: enable, role, autobaud
	logic [2:0] cfg_ff;
	logic [7:0] lin_indirect_address_ff; // Pointer into core space
	logic [7:0] length_ff; // Enhanced select and data length
	logic [7:0] divider_ff; // Divider low byte
	logic [7:0] multiplier_ff; // Prescaler, multiplier, divider bit nine
	logic [7:0] ident_ff; // Six-bit identifier
	logic sleep_ff; // Slave sleep request
	logic dir_ff; // Transmit when set
	logic ack_ff; // Slave data acknowledge
	logic wake_ff; // Wakeup request pending
	logic start_ff; // Master start request pending
	logic [4:0] err_ff; // Sticky error flags
	logic error_ff; // Summary error status
	logic int_ff; // Interrupt pending
	logic done_ff; // Transfer done
	logic wakeup_flag_ff; // Wakeup detected
	lin_state_t state_ff; // Frame engine view
	logic [7:0] core_rd; // Combinational core register read
	logic [7:0] buf_rd; // Data buffer registered read
	logic [7:0] rd_mux; // Direct register read value
	logic wr_ind; // Indirect data write strobe
	logic is_master;
	logic any_err;
	logic rst_err;
	logic rst_int;

	// Core address decode used by the read path only
	function automatic logic is_ctrl_space(input logic [7:0] a);
		return a <= `IND_IDENTIFIER;
	endfunction

	assign is_master = cfg_ff[1];
	// Sync and parity cannot occur as master, so there they are no error at all
	assign any_err = |(frame_error & (is_master ? ~`ERR_SLAVE_ONLY_MASK : 5'h1f));
	assign wr_ind = sfr_wr && (sfr_addr == `SFR_LIN_INDIRECT_DATA);
	assign rst_err = wr_ind && (lin_indirect_address_ff == `IND_CONTROL) &&
		sfr_wdata[`CTL_RESET_ERROR_BIT_BIT];
	assign rst_int = wr_ind && (lin_indirect_address_ff == `IND_CONTROL) &&
		sfr_wdata[`CTL_RESET_INTERRUPT_BIT_BIT];

	// Config register; low five bits are not stored at all
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cfg_ff <= `CFG_RESET;
		end else if (sfr_wr && sfr_addr == `SFR_LIN_CONFIG) begin
			cfg_ff <= sfr_wdata[7:5];
		end
	end

	// Pointer; data accesses never move it
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lin_indirect_address_ff <= 8'h00;
		end else if (sfr_wr && sfr_addr == `SFR_LIN_INDIRECT_ADDRESS) begin
			lin_indirect_address_ff <= sfr_wdata;
		end
	end

	// Frame data bytes live in the buffer module
	lin_data_buffer #(.DEPTH(8), .AW(3)) lin_data_buffer_i (
		.clk(clk),
		.rst(rst),
		.wr_en(wr_ind && lin_indirect_address_ff <= `IND_DATA_LAST),
		.wr_addr(lin_indirect_address_ff[2:0]),
		.wr_data(sfr_wdata),
		.rd_addr(sfr_addr == `SFR_LIN_INDIRECT_ADDRESS && sfr_wr ?
			sfr_wdata[2:0] : lin_indirect_address_ff[2:0]),
		.rd_data(buf_rd)
	);

	// Plain configuration registers in core space
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			length_ff <= 8'h00;
			divider_ff <= 8'h00;
			multiplier_ff <= 8'h00;
			ident_ff <= 8'h00;
		end else if (wr_ind) begin
			case (lin_indirect_address_ff)
				`IND_FRAME_LENGTH: length_ff <= sfr_wdata & `LEN_MASK;
				`IND_DIVIDER_LOW: divider_ff <= sfr_wdata;
				`IND_MULTIPLIER: multiplier_ff <= sfr_wdata;
				`IND_IDENTIFIER: ident_ff <= sfr_wdata & `ID_MASK;
				default: ; // Unmapped writes are dropped
			endcase
		end
	end

	// Control bits; role-specific bits only take writes in their role
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sleep_ff <= 1'b0;
			dir_ff <= 1'b0;
			ack_ff <= 1'b0;
		end else begin
			if (wr_ind && lin_indirect_address_ff == `IND_CONTROL) begin
				dir_ff <= sfr_wdata[`CTL_DIR_BIT];
				if (!is_master) begin
					sleep_ff <= sfr_wdata[`CTL_SLEEP_BIT];
				end
			end
			// Acknowledge self-clears once the engine takes it
			if (ack_taken) begin
				ack_ff <= 1'b0;
			end else if (wr_ind && lin_indirect_address_ff == `IND_CONTROL && !is_master
				&& sfr_wdata[`CTL_ACK_BIT]) begin
				ack_ff <= 1'b1;
			end
		end
	end

	// Start and wakeup requests; refused while an error is pending
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			start_ff <= 1'b0;
			wake_ff <= 1'b0;
		end else begin
			if (frame_done || any_err || !cfg_ff[2]) begin
				start_ff <= 1'b0;
			end else if (rst_err == 1'b0 && wr_ind && lin_indirect_address_ff == `IND_CONTROL
				&& sfr_wdata[`CTL_START_BIT] && is_master && !error_ff) begin
				start_ff <= 1'b1;
			end
			if (state_ff == st_wake || any_err || !cfg_ff[2]) begin
				wake_ff <= 1'b0;
			end else if (wr_ind && lin_indirect_address_ff == `IND_CONTROL
				&& sfr_wdata[`CTL_WAKE_BIT] && !error_ff) begin
				wake_ff <= 1'b1;
			end
		end
	end

	// Frame engine view: an error drops any frame back to idle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_ff <= st_idle;
		end else begin
			case (state_ff)
				st_idle: begin
					if (wake_ff) state_ff <= st_wake;
					else if (start_ff) state_ff <= st_busy;
				end
				st_busy: begin
					if (any_err || frame_done) state_ff <= st_idle;
				end
				st_wake: state_ff <= st_idle;
				default: state_ff <= st_idle;
			endcase
		end
	end

	// Error flags; a new error wins over a clear in the same cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			err_ff <= 5'h00;
			error_ff <= 1'b0;
		end else begin
			if (rst_err) begin
				err_ff <= 5'h00;
				error_ff <= 1'b0;
			end
			if (any_err) begin
				// Sync and parity cannot occur in master role
				err_ff <= (rst_err ? 5'h00 : err_ff) | (frame_error &
					(is_master ? ~`ERR_SLAVE_ONLY_MASK : 5'h1f));
				error_ff <= 1'b1;
			end
		end
	end

	// Interrupt and done flags; hold until reset-interrupt write
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			int_ff <= 1'b0;
			done_ff <= 1'b0;
			wakeup_flag_ff <= 1'b0;
		end else begin
			if (rst_int) begin
				int_ff <= 1'b0;
				done_ff <= 1'b0;
				wakeup_flag_ff <= 1'b0;
			end
			if (frame_done || wakeup_seen) done_ff <= 1'b1;
			if (wakeup_seen) wakeup_flag_ff <= 1'b1;
			if (any_err || frame_done || wakeup_seen || (data_request && !is_master)) begin
				int_ff <= 1'b1;
			end
		end
	end

	// Core register read; write-only and role-locked bits read zero
	always_comb begin
		core_rd = 8'h00;
		case (lin_indirect_address_ff)
			`IND_CONTROL: core_rd = {1'b0, sleep_ff, dir_ff, ack_ff, 1'b0, 1'b0,
				wake_ff, start_ff};
			`IND_STATUS: core_rd = {bus_active, 1'b0, 1'b0, data_request & ~is_master,
				int_ff, error_ff, wakeup_flag_ff, done_ff};
			`IND_ERROR_FLAGS: core_rd = {3'b000, err_ff};
			`IND_FRAME_LENGTH: core_rd = length_ff;
			`IND_DIVIDER_LOW: core_rd = divider_ff;
			`IND_MULTIPLIER: core_rd = multiplier_ff;
			`IND_IDENTIFIER: core_rd = ident_ff;
			default: core_rd = 8'h00; // Above the map reads zero
		endcase
	end

	// Direct register read value
	always_comb begin
		rd_mux = 8'h00;
		case (sfr_addr)
			`SFR_LIN_CONFIG: rd_mux = {cfg_ff, 5'h00};
			`SFR_LIN_INDIRECT_ADDRESS: rd_mux = lin_indirect_address_ff;
			// Data bytes come from the buffer's own register, the rest of core space from core_rd, addresses above it read zero
			`SFR_LIN_INDIRECT_DATA: rd_mux =
				(lin_indirect_address_ff <= `IND_DATA_LAST) ? buf_rd :
				is_ctrl_space(lin_indirect_address_ff) ? core_rd : 8'h00;
			default: rd_mux = 8'h00;
		endcase
	end

	// Read data registered; valid the cycle after the strobe, held until the next read
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sfr_rdata <= 8'h00;
		end else if (sfr_rd) begin
			sfr_rdata <= rd_mux;
		end
	end

	// Registered outputs to the frame engine
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			interface_enable <= 1'b0;
			role <= role_master;
			auto_baud_select <= 1'b1;
			start_request <= 1'b0;
			wakeup_request <= 1'b0;
			frame_abort <= 1'b0;
			irq <= 1'b0;
		end else begin
			interface_enable <= cfg_ff[2];
			role <= lin_role_t'(cfg_ff[1]);
			auto_baud_select <= cfg_ff[0] & ~cfg_ff[1];
			start_request <= start_ff;
			wakeup_request <= wake_ff;
			frame_abort <= any_err && state_ff == st_busy;
			irq <= int_ff;
		end
	end
endmodule

/* rtl/lin_regs_map.svh */
// Register offsets, field positions and reset values of the LIN register bank.
// Included by the register bank design file; definitions only.
`ifndef LIN_REGS_MAP_SVH
`define LIN_REGS_MAP_SVH
// Direct special function register addresses
`define SFR_LIN_CONFIG 8'hc9
`define SFR_LIN_INDIRECT_DATA 8'hd2
`define SFR_LIN_INDIRECT_ADDRESS 8'hd3
// Indirect core register addresses
`define IND_DATA_FIRST 8'h00
`define IND_DATA_LAST 8'h07
`define IND_CONTROL 8'h08
`define IND_STATUS 8'h09
`define IND_ERROR_FLAGS 8'h0a
`define IND_FRAME_LENGTH 8'h0b
`define IND_DIVIDER_LOW 8'h0c
`define IND_MULTIPLIER 8'h0d
`define IND_IDENTIFIER 8'h0e
// Config fields and reset
`define CFG_ENABLE_BIT 7
`define CFG_MASTER_BIT 6
`define CFG_AUTOBAUD_BIT 5
`define CFG_RESET 3'h3
// Control fields
`define CTL_STOP_BIT 7
`define CTL_SLEEP_BIT 6
`define CTL_DIR_BIT 5
`define CTL_ACK_BIT 4
`define CTL_RESET_INTERRUPT_BIT_BIT 3
`define CTL_RESET_ERROR_BIT_BIT 2
`define CTL_WAKE_BIT 1
`define CTL_START_BIT 0
// Status fields
`define ST_ACTIVE_BIT 7
`define ST_IDLE_BIT 6
`define ST_ABORT_BIT 5
`define ST_DATA_REQUEST_FLAG_BIT 4
`define ST_INT_BIT 3
`define ST_ERROR_BIT 2
`define ST_WAKEUP_BIT 1
`define ST_DONE_BIT 0
// Error flag width and slave-only subset
`define ERR_WIDTH 5
`define ERR_SLAVE_ONLY_MASK 5'h18
// Frame length and identifier masks
`define LEN_MASK 8'h8f
`define ID_MASK 8'h3f
`endif

/* rtl/lin_regs_pkg.sv */
// Types shared by the LIN register bank files.
// Assumes the map header supplies numeric constants.
package lin_regs_pkg;
	// Bus role
	typedef enum logic {
		role_slave = 1'b0,
		role_master = 1'b1
	} lin_role_t;
	// Frame engine state, one-hot
	typedef enum logic [2:0] {
		st_idle = 3'b001,
		st_busy = 3'b010,
		st_wake = 3'b100
	} lin_state_t;
endpackage

/* rtl/lin_data_buffer.sv */
// Eight-byte frame data buffer with registered read data.
// Assumes one clock, asynchronous active high reset; write and read ports are independent.
`timescale 1ns/1ps
module lin_data_buffer #(
	parameter int DEPTH = 8,
	parameter int AW = 3
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [7:0] wr_data,
	input wire logic [AW-1:0] rd_addr,
	output logic [7:0] rd_data
);
	// Storage, every byte cleared at reset
	logic [7:0] mem_ff [DEPTH];

	// One write port; generate keeps each byte as its own register
	for (genvar i = 0; i < DEPTH; i++) begin : g_byte
		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				mem_ff[i] <= 8'h00;
			end else if (wr_en && (wr_addr == AW'(i))) begin
				mem_ff[i] <= wr_data;
			end
		end
	end

	// Registered read so the bank can answer from a flip-flop
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_data <= 8'h00;
		end else if (wr_en && (wr_addr == rd_addr)) begin
			rd_data <= wr_data; // Forward a same-cycle write so a back-to-back read sees it
		end else begin
			rd_data <= mem_ff[rd_addr];
		end
	end
endmodule

/* dv/lin_regs_checker.sv */
// Port assertions for the LIN register bank.
// Assumes it is bound onto the top module; bus strobes may come back to back.
`timescale 1ns/1ps
module lin_regs_checker (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	input wire logic [7:0] sfr_rdata,
	input wire logic frame_done,
	input wire logic [4:0] frame_error,
	input wire logic interface_enable,
	input wire lin_regs_pkg::lin_role_t role,
	input wire logic start_request,
	input wire logic wakeup_request,
	input wire logic frame_abort,
	input wire logic irq
);
	import lin_regs_pkg::*;
	logic [7:0] ptr_ff; // Shadow of the pointer
	logic err_ff; // Shadow of the error summary
	logic ctl_wr; // Write through the pointer to control
	logic clr_int; // Reset-interrupt write
	assign ctl_wr = sfr_wr && sfr_addr == 8'hd2 && ptr_ff == 8'h08;
	assign clr_int = ctl_wr && sfr_wdata[3];
	// Pointer shadow, so control writes can be recognised
	always_ff @(posedge clk or posedge rst) begin
		if (rst) ptr_ff <= 8'h00;
		else if (sfr_wr && sfr_addr == 8'hd3) ptr_ff <= sfr_wdata;
	end
	// Error summary shadow; sync and parity count in slave role only
	always_ff @(posedge clk or posedge rst) begin
		if (rst) err_ff <= 1'b0;
		else if (|frame_error[2:0] || (|frame_error[4:3] && role == role_slave))
			err_ff <= 1'b1;
		else if (ctl_wr && sfr_wdata[2]) err_ff <= 1'b0;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_error_irq: assert property (|frame_error[2:0] |-> ##[1:3] irq)
		else $error("no interrupt after error");
	a_error_stop: assert property (|frame_error[2:0] |-> ##[1:3] !start_request)
		else $error("start request kept after error");
	a_abort_cause: assert property (frame_abort |->
		|$past(frame_error) || |$past(frame_error, 2))
		else $error("abort without error");
	a_irq_hold: assert property ($fell(irq) |->
		$past(clr_int) || $past(clr_int, 2) || $past(clr_int, 3))
		else $error("interrupt dropped without clear");
	a_start_gate: assert property ($rose(start_request) |->
		role == role_master && interface_enable && !$past(err_ff, 2))
		else $error("start while refused");
	a_wake_gate: assert property ($rose(wakeup_request) |-> !$past(err_ff, 2))
		else $error("wakeup during error");
	a_cfg_outputs: assert property (sfr_wr && sfr_addr == 8'hc9 |-> ##2
		interface_enable == $past(sfr_wdata[7], 2) && role == $past(sfr_wdata[6], 2))
		else $error("config outputs wrong");
	a_cfg_low_zero: assert property (sfr_rd && sfr_addr == 8'hc9 |->
		##1 sfr_rdata[4:0] == 5'h00)
		else $error("config low bits not zero");
	a_ctl_clear_bits: assert property (sfr_rd && sfr_addr == 8'hd2 && ptr_ff == 8'h08 |->
		##1 sfr_rdata[7] == 1'b0 && sfr_rdata[3:2] == 2'h0)
		else $error("reset bits read nonzero");
	a_unmapped_zero: assert property (sfr_rd && sfr_addr == 8'hd2 && ptr_ff > 8'h0e |->
		##1 sfr_rdata == 8'h00)
		else $error("unmapped read nonzero");
	a_ptr_read: assert property (sfr_rd && sfr_addr == 8'hd3 |->
		##1 sfr_rdata == $past(ptr_ff))
		else $error("pointer readback wrong");
	cover property ($rose(irq));
	cover property (frame_abort);
	cover property ($rose(start_request));
endmodule

/* dv/lin_core_model.sv */
// Processor core model: drives the register bus of the LIN block.
// Assumes strobes launched on falling edges, sampled on rising ones.
`timescale 1ns/1ps
module lin_core_model (
	input wire logic clk,
	output logic [7:0] sfr_addr,
	output logic sfr_wr,
	output logic sfr_rd,
	output logic [7:0] sfr_wdata,
	input wire logic [7:0] sfr_rdata
);
	// Bus idle at time zero
	initial begin
		sfr_addr = 8'h00;
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
		sfr_wdata = 8'h00;
	end
	// One write strobe held across one rising edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(negedge clk);
		sfr_wr = 1'b0;
		sfr_wdata = ~d; // Stale data must not pass for a held value
	endtask
	// Read data is registered, so take it one cycle later
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		sfr_addr = a;
		sfr_rd = 1'b1;
		@(negedge clk);
		sfr_rd = 1'b0;
		@(negedge clk);
		d = sfr_rdata;
	endtask
endmodule

/* dv/lin_register_access_and_errors_bench.sv */
// Self-checking bench for the LIN register bank.
// Assumes the core model drives the bus and the bench plays the frame engine.
`timescale 1ns/1ps
module lin_register_access_and_errors_bench;
	import lin_regs_pkg::*;
	logic clk, rst, frame_done, sfr_wr, sfr_rd, interface_enable, auto_baud_select;
	logic start_request, wakeup_request, frame_abort, irq, ab;
	logic bus_active, data_request, wakeup_seen, ack_taken;
	logic [4:0] frame_error;
	logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, v;
	lin_role_t role;
	int n_mismatch, total_checks;
	// Pointer, written byte, expected readback
	logic [23:0] rows [10] = '{24'h0b_ff_8f, 24'h0e_ff_3f, 24'h0c_a5_a5, 24'h0d_5a_5a,
		24'h0a_ff_00, 24'h09_ff_00, 24'h0f_ff_00, 24'hff_12_00, 24'h00_c3_c3,
		24'h07_3c_3c};
	lin_core_model lin_core_model_i (.clk, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata);
	lin_register_access_and_errors lin_register_access_and_errors_i (.clk, .rst, .sfr_addr,
		.sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .frame_done, .frame_error,
		.bus_active, .data_request, .wakeup_seen, .ack_taken,
		.interface_enable, .role, .auto_baud_select, .start_request, .wakeup_request,
		.frame_abort, .irq);
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
			n_mismatch++;
		end
	endtask
	task automatic ind_wr(input logic [7:0] p, input logic [7:0] d);
		lin_core_model_i.wr(8'hd3, p);
		lin_core_model_i.wr(8'hd2, d);
	endtask
	task automatic ind_rd(input logic [7:0] p, input logic [7:0] e);
		lin_core_model_i.wr(8'hd3, p);
		lin_core_model_i.rd(8'hd2, v);
		chk(v, e);
	endtask
	// Engine event pulse, then time for the outputs to follow
	task automatic pulse(input logic dn, input logic [4:0] e);
		@(negedge clk);
		frame_done = dn;
		frame_error = e;
		@(negedge clk);
		ab = frame_abort; // Abort pulse stands for the one cycle after the event
		frame_done = 1'b0;
		frame_error = 5'h00;
		repeat (3) @(negedge clk);
	endtask
	task automatic end_sim;
		$display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// Watchdog: the sequence needs well under a thousand cycles
	initial begin
		#50000;
		n_mismatch++;
		end_sim();
	end
	initial begin
		rst = 1'b1;
		frame_done = 1'b0;
		frame_error = 5'h00;
		bus_active = 1'b0;
		data_request = 1'b0;
		wakeup_seen = 1'b0;
		ack_taken = 1'b0;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		chk({6'h00, role, interface_enable}, 8'h02);
		lin_core_model_i.rd(8'hc9, v);
		chk(v, 8'h60);
		lin_core_model_i.wr(8'hc9, 8'hff);
		lin_core_model_i.rd(8'hc9, v);
		chk(v, 8'he0);
		foreach (rows[i]) begin
			ind_wr(rows[i][23:16], rows[i][15:8]);
			lin_core_model_i.rd(8'hd3, v);
			chk(v, rows[i][23:16]);
			ind_rd(rows[i][23:16], rows[i][7:0]);
		end
		ind_wr(8'h08, 8'h01);
		repeat (3) @(negedge clk);
		chk({7'h00, start_request}, 8'h01);
		pulse(1'b1, 5'h00);
		chk({7'h00, start_request}, 8'h00);
		ind_wr(8'h08, 8'h08);
		// Each error kind of the master role, mid-frame
		for (int b = 0; b < 3; b++) begin
			ind_wr(8'h08, 8'h01);
			pulse(1'b0, 5'(1 << b));
			chk({5'h00, ab, irq, start_request}, 8'h06);
			ind_rd(8'h09, 8'h0c);
			ind_rd(8'h0a, 8'(1 << b));
			ind_wr(8'h08, 8'h01);
			ind_wr(8'h08, 8'h02);
			@(negedge clk);
			chk({6'h00, start_request, wakeup_request}, 8'h00);
			ind_wr(8'h08, 8'h04);
			ind_rd(8'h0a, 8'h00);
			ind_rd(8'h09, 8'h08);
			lin_core_model_i.wr(8'hd3, 8'h08);
			lin_core_model_i.rd(8'hd2, v);
			chk({v[7], v[3:2], 4'h0, irq}, 8'h01);
			ind_wr(8'h08, 8'h08);
			repeat (3) @(negedge clk);
			chk({7'h00, irq}, 8'h00);
		end
		ind_wr(8'h08, 8'h02);
		@(negedge clk);
		chk({7'h00, wakeup_request}, 8'h01);
		pulse(1'b1, 5'h18);
		ind_rd(8'h0a, 8'h00);
		lin_core_model_i.wr(8'hc9, 8'ha0);
		ind_wr(8'h08, 8'h01);
		repeat (3) @(negedge clk);
		chk({6'h00, auto_baud_select, start_request}, 8'h02);
		pulse(1'b0, 5'h10);
		ind_rd(8'h0a, 8'h10);
		// Slave-side engine inputs: request, bus activity, wakeup, acknowledge
		data_request = 1'b1;
		bus_active = 1'b1;
		wakeup_seen = 1'b1;
		@(negedge clk);
		wakeup_seen = 1'b0;
		ind_rd(8'h09, 8'h9f);
		ind_wr(8'h08, 8'h10);
		ind_rd(8'h08, 8'h10);
		ack_taken = 1'b1;
		@(negedge clk);
		ack_taken = 1'b0;
		ind_rd(8'h08, 8'h00);
		// Second reset in mid-run
		rst = 1'b1;
		@(negedge clk);
		rst = 1'b0;
		chk({6'h00, role, interface_enable}, 8'h02);
		lin_core_model_i.rd(8'hc9, v);
		chk(v, 8'h60);
		ind_rd(8'h0a, 8'h00);
		ind_rd(8'h00, 8'h00);
		ind_rd(8'h07, 8'h00);
		end_sim();
	end
endmodule
bind lin_register_access_and_errors lin_regs_checker lin_regs_checker_i (.clk, .rst, .sfr_addr,
	.sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .frame_done, .frame_error, .interface_enable,
	.role, .start_request, .wakeup_request, .frame_abort, .irq);
